// >>> logic/bcd_muldiv_regs.svh
// Opcodes, reset values and constants of the BCD multiply/divide unit
`ifndef BCD_MULDIV_REGS_SVH
`define BCD_MULDIV_REGS_SVH

`define MULTIPLY_OPCODE          8'h73
`define DIVIDE_OPCODE            8'h74
`define LOAD_ACCUMULATOR_OPCODE  8'h50

`define ACC_RESET                16'h0000
`define AUX_RESET                16'h0000
`define BIN_RESET                14'h0000

`define FRACTION_SCALE           28'h0002710
`define RESULT_LATENCY           2

`endif

// >>> logic/bcd_muldiv_pkg.sv
// Types of the BCD multiply/divide unit
package bcd_muldiv_pkg;

   typedef enum logic [1:0]
   {
      SRC_WORD  = 2'h0,
      SRC_PAIR  = 2'h1,
      SRC_CONST = 2'h2,
      SRC_AUX   = 2'h3
   } operand_src_t;

   typedef struct packed
   {
      logic [7:0]   opcode;
      operand_src_t src;
      logic [15:0]  reg_word;
      logic [7:0]   byte_low;
      logic [7:0]   byte_high;
      logic [15:0]  konst;
   } command_t;

   typedef struct packed
   {
      logic zero;
      logic div_zero;
   } status_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_CALC = 2'b10
   } unit_fsm_t;

   typedef struct packed
   {
      unit_fsm_t   fsm;
      logic        is_div;
      logic [13:0] a_bin;
      logic [13:0] b_bin;
      logic [15:0] acc;
      logic [15:0] aux;
      status_t     flags;
      logic        done;
   } unit_state_t;

endpackage : bcd_muldiv_pkg

// >>> logic/bcd_multiply_divide_unit.sv
// BCD multiply/divide unit on the 16-bit accumulator with auxiliary accumulator
//
// Behaviour
// - A multiply takes the accumulator times an operand from a word register, a byte pair, a BCD constant or the auxiliary pair.
// - A multiply leaves the low four product digits in the accumulator and the high four in the auxiliary pair.
// - A multiply whose product is zero sets the zero flag.
// - A divide takes the accumulator as dividend and the selected operand as divisor.
// - A divide by a nonzero divisor leaves the integer quotient in the accumulator and four fraction digits in the auxiliary pair.
// - A divide sets the zero flag when dividend or divisor is zero.
// - A divide sets the divide-by-zero flag when the divisor is zero.
// - The auxiliary pair is readable as a register pair, so a load can bring it into the accumulator.
`timescale 1ns/100ps
`include "bcd_muldiv_regs.svh"

module bcd_multiply_divide_unit
(
   input  wire logic                     sys_clk_i,
   input  wire logic                     sys_rst_i,
   input  wire logic                     cmd_valid_i,
   input  wire bcd_muldiv_pkg::command_t cmd_i,
   output logic                          busy_o,
   output logic                          done_o,
   output logic [15:0]                   acc_o,
   output logic [15:0]                   aux_o,
   output bcd_muldiv_pkg::status_t       status_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers

   function automatic logic [13:0] bcd2bin(input logic [15:0] d);
      logic [17:0] s;
      s = 18'(d[15:12]) * 18'h003E8 + 18'(d[11:8]) * 18'h00064 + 18'(d[7:4]) * 18'h0000A + 18'(d[3:0]);
      return s[13:0];
   endfunction : bcd2bin

   function automatic logic [31:0] bin2bcd(input logic [27:0] b);
      logic [31:0] r;
      r = 32'h00000000;
      for (int i = 27; i >= 0; i--)
      begin
         for (int k = 0; k < 8; k++)
         begin
            if (r[4*k +: 4] > 4'h4)
            begin
               r[4*k +: 4] = r[4*k +: 4] + 4'h3;
            end
         end
         r = {r[30:0], b[i]};
      end
      return r;
   endfunction : bin2bcd

   function automatic logic [15:0] pick_operand(input bcd_muldiv_pkg::command_t c, input logic [15:0] aux);
      case (c.src)
         bcd_muldiv_pkg::SRC_WORD:  return c.reg_word;
         bcd_muldiv_pkg::SRC_PAIR:  return {c.byte_high, c.byte_low};
         bcd_muldiv_pkg::SRC_CONST: return c.konst;
         default:                   return aux;
      endcase
   endfunction : pick_operand

   ////////////////////////////////////////////////////////////////////////////
   // State and datapath

   bcd_muldiv_pkg::unit_state_t st;
   bcd_muldiv_pkg::unit_state_t next_st;
   logic [15:0]                 operand;
   logic                        is_mul_cmd;
   logic                        is_div_cmd;
   logic [13:0]                 b_safe;
   logic [27:0]                 product;
   logic [13:0]                 quotient;
   logic [13:0]                 remainder;
   logic [27:0]                 fraction;
   logic [31:0]                 product_bcd;
   logic [31:0]                 quotient_bcd;
   logic [31:0]                 fraction_bcd;

   assign operand     = pick_operand(cmd_i, st.aux);
   assign is_mul_cmd  = cmd_valid_i && (cmd_i.opcode == `MULTIPLY_OPCODE);
   assign is_div_cmd  = cmd_valid_i && (cmd_i.opcode == `DIVIDE_OPCODE);
   assign b_safe      = (st.b_bin == `BIN_RESET) ? 14'h0001 : st.b_bin;
   assign product     = 28'(st.a_bin) * 28'(st.b_bin);
   assign product_bcd = bin2bcd(product);
   assign quotient    = st.a_bin / b_safe;
   assign remainder   = st.a_bin % b_safe;
   assign fraction    = (28'(remainder) * `FRACTION_SCALE) / 28'(b_safe);
   assign quotient_bcd = bin2bcd(28'(quotient));
   assign fraction_bcd = bin2bcd(fraction);

   always_comb
   begin
      next_st      = st;
      next_st.done = 1'b0;
      case (st.fsm)
         bcd_muldiv_pkg::ST_IDLE:
         begin
            if (is_mul_cmd || is_div_cmd)
            begin
               next_st.a_bin  = bcd2bin(st.acc);
               next_st.b_bin  = bcd2bin(operand);
               next_st.is_div = is_div_cmd;
               next_st.fsm    = bcd_muldiv_pkg::ST_CALC;
            end
            else if (cmd_valid_i && (cmd_i.opcode == `LOAD_ACCUMULATOR_OPCODE))
            begin
               next_st.acc = operand;
            end
         end
         bcd_muldiv_pkg::ST_CALC:
         begin
            next_st.fsm  = bcd_muldiv_pkg::ST_IDLE;
            next_st.done = 1'b1;
            if (!st.is_div)
            begin
               next_st.acc        = product_bcd[15:0];
               next_st.aux        = product_bcd[31:16];
               next_st.flags.zero = (product == 28'h0000000);
            end
            else
            begin
               next_st.flags.zero     = (st.a_bin == `BIN_RESET) || (st.b_bin == `BIN_RESET);
               next_st.flags.div_zero = (st.b_bin == `BIN_RESET);
               if (st.b_bin != `BIN_RESET)
               begin
                  next_st.acc = quotient_bcd[15:0];
                  next_st.aux = fraction_bcd[15:0];
               end
            end
         end
         default:
         begin
            next_st.fsm = bcd_muldiv_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         st.fsm            <= bcd_muldiv_pkg::ST_IDLE;
         st.is_div         <= 1'b0;
         st.a_bin          <= `BIN_RESET;
         st.b_bin          <= `BIN_RESET;
         st.acc            <= `ACC_RESET;
         st.aux            <= `AUX_RESET;
         st.flags.zero     <= 1'b0;
         st.flags.div_zero <= 1'b0;
         st.done           <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign busy_o   = (st.fsm == bcd_muldiv_pkg::ST_CALC);
   assign done_o   = st.done;
   assign acc_o    = st.acc;
   assign aux_o    = st.aux;
   assign status_o = st.flags;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic idle;
   assign idle = (st.fsm == bcd_muldiv_pkg::ST_IDLE);

   a_mul_digits: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_mul_cmd |-> ##2
      {aux_o, acc_o} == bin2bcd(28'(bcd2bin($past(acc_o, 2))) * 28'(bcd2bin($past(operand, 2)))))
      else $error("Multiply result digits wrong");

   a_mul_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_mul_cmd |-> ##2
      status_o.zero == ((bcd2bin($past(acc_o, 2)) == 14'h0000) || (bcd2bin($past(operand, 2)) == 14'h0000)))
      else $error("Multiply zero flag wrong");

   a_div_quotient: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_div_cmd && (bcd2bin(operand) != 14'h0000) |-> ##2
      bcd2bin(acc_o) == bcd2bin($past(acc_o, 2)) / bcd2bin($past(operand, 2)))
      else $error("Divide integer part wrong");

   a_div_fraction: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_div_cmd && (bcd2bin(operand) != 14'h0000) |-> ##2
      28'(bcd2bin(aux_o)) == (28'(bcd2bin($past(acc_o, 2)) % bcd2bin($past(operand, 2))) * 28'h0002710)
                             / 28'(bcd2bin($past(operand, 2))))
      else $error("Divide fraction digits wrong");

   a_div_zero_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_div_cmd |-> ##2
      status_o.zero == ((bcd2bin($past(acc_o, 2)) == 14'h0000) || (bcd2bin($past(operand, 2)) == 14'h0000)))
      else $error("Divide zero flag wrong");

   a_div_by_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_div_cmd |-> ##2 status_o.div_zero == (bcd2bin($past(operand, 2)) == 14'h0000))
      else $error("Divide-by-zero flag wrong");

   a_div_zero_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && is_div_cmd && (bcd2bin(operand) == 14'h0000) |-> ##2 $stable(acc_o) && $stable(aux_o))
      else $error("Divide by zero altered accumulators");

   a_aux_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && cmd_valid_i && (cmd_i.opcode == 8'h50) && (cmd_i.src == bcd_muldiv_pkg::SRC_AUX)
      |=> acc_o == $past(aux_o))
      else $error("Auxiliary load into accumulator failed");

   a_done_timing: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle && (is_mul_cmd || is_div_cmd) |=> busy_o ##1 (done_o && !busy_o) ##1 !done_o)
      else $error("Done pulse timing wrong");

   c_mul_wide: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      done_o && !st.is_div && (aux_o != 16'h0000));
   c_div_fraction: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      done_o && st.is_div && !status_o.div_zero && (aux_o != 16'h0000));
   c_div_by_zero: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      done_o && status_o.div_zero);
   c_busy_refused: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      busy_o && cmd_valid_i);

endmodule : bcd_multiply_divide_unit

// >>> test/tb.sv
// Self-checking testbench of the BCD multiply/divide unit
`timescale 1ns/100ps
`include "bcd_muldiv_regs.svh"

module tb;
   localparam logic [7:0] op_prod = `MULTIPLY_OPCODE;
   localparam logic [7:0] op_quot = `DIVIDE_OPCODE;
   localparam logic [7:0] op_load = `LOAD_ACCUMULATOR_OPCODE;
   localparam bcd_muldiv_pkg::operand_src_t s_word = bcd_muldiv_pkg::SRC_WORD;
   localparam bcd_muldiv_pkg::operand_src_t s_pair = bcd_muldiv_pkg::SRC_PAIR;
   localparam bcd_muldiv_pkg::operand_src_t s_cnst = bcd_muldiv_pkg::SRC_CONST;
   localparam bcd_muldiv_pkg::operand_src_t s_aux  = bcd_muldiv_pkg::SRC_AUX;

   logic                     sys_clk_i;
   logic                     sys_rst_i;
   logic                     cmd_valid_i;
   bcd_muldiv_pkg::command_t cmd_i;
   logic                     busy_o;
   logic                     done_o;
   logic [15:0]              acc_o;
   logic [15:0]              aux_o;
   bcd_muldiv_pkg::status_t  status_o;
   int                       fails;
   int                       checked;

   bcd_multiply_divide_unit dut_u
   (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .cmd_valid_i (cmd_valid_i),
      .cmd_i       (cmd_i),
      .busy_o      (busy_o),
      .done_o      (done_o),
      .acc_o       (acc_o),
      .aux_o       (aux_o),
      .status_o    (status_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic stop_test;
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic chk_all(input logic [15:0] acc, input logic [15:0] aux, input logic z, input logic dz);
      chk("acc", acc, acc_o);
      chk("aux", aux, aux_o);
      chk("zero", {15'h0000, z}, {15'h0000, status_o.zero});
      chk("div_zero", {15'h0000, dz}, {15'h0000, status_o.div_zero});
   endtask : chk_all

   task automatic do_reset(input int n);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b1;
      repeat (n) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      chk_all(16'h0000, 16'h0000, 1'b0, 1'b0);
      chk("busy_rst", 16'h0000, {15'h0000, busy_o});
   endtask : do_reset

   // Unselected operand fields carry a decoy value; poke tries a load while busy
   task automatic step(input logic [7:0] opc, input bcd_muldiv_pkg::operand_src_t s, input logic [15:0] v,
                       input bit poke, input logic [15:0] acc, input logic [15:0] aux, input logic z,
                       input logic dz);
      @(negedge sys_clk_i);
      cmd_valid_i = 1'b1;
      cmd_i.opcode = opc;
      cmd_i.src = s;
      cmd_i.reg_word = (s == s_word) ? v : 16'h0003;
      {cmd_i.byte_high, cmd_i.byte_low} = (s == s_pair) ? v : 16'h0003;
      cmd_i.konst = (s == s_cnst) ? v : 16'h0003;
      @(negedge sys_clk_i);
      cmd_valid_i = poke;
      cmd_i.opcode = op_load;
      cmd_i.src = s_cnst;
      cmd_i.konst = 16'h7777;
      if (opc != op_load)
      begin
         chk("busy", 16'h0001, {15'h0000, busy_o});
         chk("done_early", 16'h0000, {15'h0000, done_o});
         @(negedge sys_clk_i);
         cmd_valid_i = 1'b0;
         chk("done", 16'h0001, {15'h0000, done_o});
         chk("busy_end", 16'h0000, {15'h0000, busy_o});
         @(negedge sys_clk_i);
         chk("done_end", 16'h0000, {15'h0000, done_o});
      end
      chk_all(acc, aux, z, dz);
   endtask : step

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3000) @(posedge sys_clk_i);
      fails++;
      stop_test();
   end

   initial
   begin
      fails = 0;
      checked = 0;
      sys_rst_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_i = '0;
      repeat (4) @(negedge sys_clk_i);
      do_reset(1);
      step(op_load, s_cnst, 16'h3619, 1'b0, 16'h3619, 16'h0000, 1'b0, 1'b0);
      step(op_prod, s_cnst, 16'h0002, 1'b0, 16'h7238, 16'h0000, 1'b0, 1'b0);
      step(op_load, s_word, 16'h9999, 1'b0, 16'h9999, 16'h0000, 1'b0, 1'b0);
      step(op_prod, s_word, 16'h9999, 1'b0, 16'h0001, 16'h9998, 1'b0, 1'b0);
      step(op_load, s_aux, 16'h0000, 1'b0, 16'h9998, 16'h9998, 1'b0, 1'b0);
      step(op_load, s_pair, 16'h5000, 1'b0, 16'h5000, 16'h9998, 1'b0, 1'b0);
      step(op_prod, s_pair, 16'h0002, 1'b0, 16'h0000, 16'h0001, 1'b0, 1'b0);
      step(op_prod, s_cnst, 16'h0000, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b0);
      step(op_load, s_cnst, 16'h0529, 1'b0, 16'h0529, 16'h0000, 1'b1, 1'b0);
      step(op_quot, s_cnst, 16'h0032, 1'b1, 16'h0016, 16'h5312, 1'b0, 1'b0);
      step(op_load, s_aux, 16'h0000, 1'b0, 16'h5312, 16'h5312, 1'b0, 1'b0);
      step(op_load, s_cnst, 16'h0530, 1'b0, 16'h0530, 16'h5312, 1'b0, 1'b0);
      step(op_quot, s_word, 16'h0010, 1'b0, 16'h0053, 16'h0000, 1'b0, 1'b0);
      step(op_quot, s_cnst, 16'h0000, 1'b0, 16'h0053, 16'h0000, 1'b1, 1'b1);
      step(op_prod, s_cnst, 16'h0001, 1'b0, 16'h0053, 16'h0000, 1'b0, 1'b1);
      step(op_load, s_cnst, 16'h0007, 1'b0, 16'h0007, 16'h0000, 1'b0, 1'b1);
      step(op_quot, s_pair, 16'h0003, 1'b0, 16'h0002, 16'h3333, 1'b0, 1'b0);
      step(op_load, s_cnst, 16'h0000, 1'b0, 16'h0000, 16'h3333, 1'b0, 1'b0);
      step(op_quot, s_pair, 16'h0005, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0);
      step(op_quot, s_word, 16'h0000, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b1);
      step(op_load, s_cnst, 16'h1234, 1'b0, 16'h1234, 16'h0000, 1'b1, 1'b1);
      do_reset(2);
      stop_test();
   end
endmodule : tb
